// File: shared/smd_pkg.sv
package smd_pkg;
  // ---------------------------------------------------------------
  // Special function register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_PRESCALER = 8'hd2;
  localparam logic [7:0] OFS_STATUS = 8'hd3;
  localparam logic [7:0] OFS_TX_HOLD = 8'hd4;
  localparam logic [7:0] OFS_RX_HOLD = 8'hd5;
  localparam logic [7:0] OFS_CONTROL = 8'hd6;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'hd7;

  // ---------------------------------------------------------------
  // Values after reset and writable bits
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PRESCALER = 8'h04;
  localparam logic [7:0] RST_STATUS = 8'h02;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] MASK_PRESCALER = 8'hfc;
  localparam logic [7:0] MASK_CONTROL = 8'h7e;
  localparam logic [7:0] MASK_IRQ_ENABLE = 8'h0f;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTL_TRANSMITTER_ENABLE = 6;
  localparam int CTL_RECEIVER_ENABLE = 5;
  localparam int CTL_GLOBAL_ENABLE = 4;
  localparam int CTL_SELECT_AUTO = 3;
  localparam int CTL_LSB_FIRST = 2;
  localparam int CTL_IDLE_POLARITY = 1;
  localparam int PRE_WEIGHT_LSB = 2;
  localparam int STA_BUSY = 4;
  localparam int STA_XFER_END = 3;
  localparam int STA_OVERRUN = 2;
  localparam int STA_TX_EMPTY = 1;
  localparam int STA_RX_FULL = 0;

  // ---------------------------------------------------------------
  // Timing: half period in link cycles for the least divisor of 4
  // ---------------------------------------------------------------
  localparam logic [6:0] MIN_HALF_CYCLES = 7'h02;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [3:0] {
    LNK_IDLE = 4'b0001,
    LNK_LEAD = 4'b0010,
    LNK_SHIFT = 4'b0100,
    LNK_DONE = 4'b1000
  } smd_link_state_type;
endpackage : smd_pkg

// File: hdl/smd_sync.sv
`timescale 1ns/10ps
`default_nettype none
module smd_sync
  import smd_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Destination clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Foreign level and its settled copy
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;
  logic [W-1:0] next_q;

  // A bit counts only once stages two and three agree
  always_comb begin
    next_q = q_o;
    for (int i = 0; i < W; i++) begin
      if (ff2[i] == ff3[i]) begin
        next_q[i] = ff3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    ff1 <= d_i;
    ff2 <= ff1;
    ff3 <= ff2;
    if (rst_i) begin
      q_o <= RST_VAL;
    end else begin
      q_o <= next_q;
    end
  end
endmodule : smd_sync
`default_nettype wire

// File: hdl/smd_top.sv
// Overview of operation
// - Shift out only with transmitter enabled; capture only with receiver enabled.
// - Transmitter disabled holds serial clock at idle level, halting all traffic.
// - Automatic select drives low before each byte, high after eighth bit.
// - Without automatic select, select stays high once current transfer ends.
// - Global enable clear disables the whole interface; set enables it.
// - Order bit 0 sends MSB first, 1 LSB first, both directions.
// - Polarity 0 idles low, samples falling; polarity 1 idles high, samples rising.
// - Prescaler bits 7..2 weigh 128 down to 4; bits 1..0 unused.
// - Four interrupt enables let their conditions raise the single interrupt.
// - Transfer-end flag sets at byte end, clears on status read.
// - Overrun flag sets on overrun, clears on status read.
// - Transmit-empty sets when byte enters shifter, clears after holding write.
// - Receive-full sets when holding register fills, clears when it is read.
// - Busy reads 1 while a byte is shifting, 0 once done.
// - Status resets to 02h, controls to 00h, prescaler to 04h.
// - Serial clock period is peripheral clock times sum of set weights.
// - First data bit driven on first clock edge, sampled on opposite edge.
// - Transmit and receive paths are double buffered by holding registers.
`timescale 1ns/10ps
`default_nettype none
module smd_top
  import smd_pkg::*;
(
  // Core clock, peripheral clock, reset
  input wire logic mclk_i,
  input wire logic peripheral_clock_i,
  input wire logic rst_i,
  // Special function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Interrupt to the core
  output logic spi_irq_o,
  // Serial pins
  output logic serial_clock_out_o,
  output logic serial_data_out_o,
  output logic slave_select_out_o,
  input wire logic serial_data_in_i
);
  // ---------------------------------------------------------------
  // Core-side registers
  // ---------------------------------------------------------------
  logic [7:0] prescaler, next_prescaler;
  logic [7:0] control, next_control;
  logic [7:0] irq_enable, next_irq_enable;
  logic [7:0] tx_hold, next_tx_hold;
  logic tx_full, next_tx_full;
  logic req_tog, next_req_tog;
  logic [7:0] rx_hold, next_rx_hold;
  logic rx_full, next_rx_full;
  logic end_flag, next_end_flag;
  logic ovr_flag, next_ovr_flag;
  logic rx_seen, next_rx_seen;
  logic end_seen, next_end_seen;
  logic ack_seen, next_ack_seen;
  logic [7:0] next_rdata;
  logic next_irq;
  logic [3:0] back_s;
  logic rx_evt, end_evt, ack_evt, busy_s;
  logic [7:0] status;

  // ---------------------------------------------------------------
  // Link-side registers
  // ---------------------------------------------------------------
  smd_link_state_type lst, next_lst;
  logic l_rst;
  logic [12:0] cfg_s;
  logic l_en, l_te, l_re, l_auto, l_lsb, l_cpol, l_req;
  logic [5:0] l_weights;
  logic l_din;
  logic [6:0] cnt, next_cnt;
  logic [6:0] half_len;
  logic tick, l_go;
  logic [2:0] bitn, next_bitn;
  logic half, next_half;
  logic [7:0] tx_sh, next_tx_sh;
  logic [7:0] rx_sh, next_rx_sh;
  logic [7:0] l_rxw, next_l_rxw;
  logic fr_lsb, next_fr_lsb;
  logic fr_re, next_fr_re;
  logic fr_auto, next_fr_auto;
  logic l_rx_tog, next_l_rx_tog;
  logic l_end_tog, next_l_end_tog;
  logic l_ack_tog, next_l_ack_tog;
  logic l_busy, next_l_busy;
  logic next_sclk, next_mosi, next_sel;

  // ---------------------------------------------------------------
  // Crossings
  // ---------------------------------------------------------------
  smd_sync #(.W(1), .RST_VAL(1'b1)) u_rst_sync (
    .clk_i(peripheral_clock_i),
    .rst_i(1'b0),
    .d_i(rst_i),
    .q_o(l_rst)
  );
  // Settings are quasi-static; change them only while idle
  smd_sync #(.W(13), .RST_VAL(13'h0000)) u_cfg_sync (
    .clk_i(peripheral_clock_i),
    .rst_i(l_rst),
    .d_i({control[6:1], prescaler[7:2], req_tog}),
    .q_o(cfg_s)
  );
  smd_sync #(.W(1), .RST_VAL(1'b0)) u_din_sync (
    .clk_i(peripheral_clock_i),
    .rst_i(l_rst),
    .d_i(serial_data_in_i),
    .q_o(l_din)
  );
  smd_sync #(.W(4), .RST_VAL(4'h0)) u_back_sync (
    .clk_i(mclk_i),
    .rst_i(rst_i),
    .d_i({l_busy, l_rx_tog, l_end_tog, l_ack_tog}),
    .q_o(back_s)
  );
  assign {l_te, l_re, l_en, l_auto, l_lsb, l_cpol} = cfg_s[12:7];
  assign l_weights = cfg_s[6:1];
  assign l_req = cfg_s[0];
  assign busy_s = back_s[3];
  assign rx_evt = back_s[2] != rx_seen;
  assign end_evt = back_s[1] != end_seen;
  assign ack_evt = back_s[0] != ack_seen;
  assign status = {3'b000, busy_s, end_flag, ovr_flag, ~tx_full, rx_full};

  // ---------------------------------------------------------------
  // Core-side register file
  // ---------------------------------------------------------------
  always_comb begin
    next_prescaler = prescaler;
    next_control = control;
    next_irq_enable = irq_enable;
    next_tx_hold = tx_hold;
    next_tx_full = tx_full;
    next_req_tog = req_tog;
    next_rx_hold = rx_hold;
    next_rx_full = rx_full;
    next_end_flag = end_flag;
    next_ovr_flag = ovr_flag;
    next_rx_seen = back_s[2];
    next_end_seen = back_s[1];
    next_ack_seen = back_s[0];
    next_rdata = sfr_rdata_o;
    // Byte has reached the shifter: holding register is free again
    if (ack_evt) begin
      next_tx_full = 1'b0;
    end
    // Hand a held byte over once the previous hand-over has closed
    if (tx_full && !ack_evt && (req_tog == ack_seen)) begin
      next_req_tog = ~req_tog;
    end
    if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        OFS_PRESCALER: next_rdata = prescaler;
        OFS_STATUS: next_rdata = status;
        OFS_RX_HOLD: next_rdata = rx_hold;
        OFS_CONTROL: next_rdata = control;
        OFS_IRQ_ENABLE: next_rdata = irq_enable;
        default: next_rdata = 8'h00;
      endcase
      if (sfr_addr_i == OFS_STATUS) begin
        next_end_flag = 1'b0;
        next_ovr_flag = 1'b0;
      end
      if (sfr_addr_i == OFS_RX_HOLD) begin
        next_rx_full = 1'b0;
      end
    end
    if (sfr_wr_i) begin
      unique case (sfr_addr_i)
        OFS_PRESCALER: next_prescaler = sfr_wdata_i & MASK_PRESCALER;
        OFS_CONTROL: next_control = sfr_wdata_i & MASK_CONTROL;
        OFS_IRQ_ENABLE: next_irq_enable = sfr_wdata_i & MASK_IRQ_ENABLE;
        OFS_TX_HOLD: begin
          // A write while the holding register is still full is dropped
          if (!tx_full || ack_evt) begin
            next_tx_hold = sfr_wdata_i;
            next_tx_full = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Hardware sets win over same-cycle clears
    if (rx_evt) begin
      next_rx_hold = l_rxw;
      next_rx_full = 1'b1;
      if (rx_full && !(sfr_rd_i && sfr_addr_i == OFS_RX_HOLD)) begin
        next_ovr_flag = 1'b1;
      end
    end
    if (end_evt) begin
      next_end_flag = 1'b1;
    end
    next_irq = |(status[3:0] & irq_enable[3:0]);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prescaler <= RST_PRESCALER;
      control <= RST_CONTROL;
      irq_enable <= RST_IRQ_ENABLE;
      tx_hold <= 8'h00;
      tx_full <= ~RST_STATUS[STA_TX_EMPTY];
      req_tog <= 1'b0;
      rx_hold <= 8'h00;
      rx_full <= RST_STATUS[STA_RX_FULL];
      end_flag <= RST_STATUS[STA_XFER_END];
      ovr_flag <= RST_STATUS[STA_OVERRUN];
      rx_seen <= 1'b0;
      end_seen <= 1'b0;
      ack_seen <= 1'b0;
      sfr_rdata_o <= 8'h00;
      spi_irq_o <= 1'b0;
    end else begin
      prescaler <= next_prescaler;
      control <= next_control;
      irq_enable <= next_irq_enable;
      tx_hold <= next_tx_hold;
      tx_full <= next_tx_full;
      req_tog <= next_req_tog;
      rx_hold <= next_rx_hold;
      rx_full <= next_rx_full;
      end_flag <= next_end_flag;
      ovr_flag <= next_ovr_flag;
      rx_seen <= next_rx_seen;
      end_seen <= next_end_seen;
      ack_seen <= next_ack_seen;
      sfr_rdata_o <= next_rdata;
      spi_irq_o <= next_irq;
    end
  end

  // ---------------------------------------------------------------
  // Link engine on the peripheral clock
  // ---------------------------------------------------------------
  // Half period is the weight sum over two; no weight set acts as 4
  assign half_len = (l_weights == 6'h00) ? MIN_HALF_CYCLES : {l_weights, 1'b0};
  assign tick = cnt == (half_len - 7'h01);
  assign l_go = l_en && l_te && (l_req != l_ack_tog);

  always_comb begin
    next_lst = lst;
    next_cnt = cnt + 7'h01;
    next_bitn = bitn;
    next_half = half;
    next_tx_sh = tx_sh;
    next_rx_sh = rx_sh;
    next_l_rxw = l_rxw;
    next_fr_lsb = fr_lsb;
    next_fr_re = fr_re;
    next_fr_auto = fr_auto;
    next_l_rx_tog = l_rx_tog;
    next_l_end_tog = l_end_tog;
    next_l_ack_tog = l_ack_tog;
    next_l_busy = l_busy;
    next_sclk = serial_clock_out_o;
    next_mosi = serial_data_out_o;
    next_sel = slave_select_out_o;
    if (lst != LNK_IDLE && !(l_en && l_te)) begin
      // Disable aborts the byte and parks clock and select; data out keeps its last bit
      next_lst = LNK_IDLE;
      next_sclk = l_cpol;
      next_sel = 1'b1;
      next_l_busy = 1'b0;
    end else begin
      unique case (lst)
        LNK_IDLE: begin
          next_cnt = 7'h00;
          next_sclk = l_cpol;
          next_sel = 1'b1;
          if (l_go) begin
            next_tx_sh = tx_hold;
            next_l_ack_tog = ~l_ack_tog;
            next_fr_lsb = l_lsb;
            next_fr_re = l_re;
            next_fr_auto = l_auto;
            next_sel = ~l_auto;
            next_l_busy = 1'b1;
            next_lst = LNK_LEAD;
          end
        end
        LNK_LEAD: begin
          if (tick) begin
            // Leading edge carries out the first bit
            next_cnt = 7'h00;
            next_sclk = ~l_cpol;
            next_mosi = fr_lsb ? tx_sh[0] : tx_sh[7];
            next_tx_sh = fr_lsb ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
            next_bitn = 3'h0;
            next_half = 1'b0;
            next_lst = LNK_SHIFT;
          end
        end
        LNK_SHIFT: begin
          if (tick) begin
            next_cnt = 7'h00;
            if (!half) begin
              next_sclk = l_cpol;
              next_rx_sh = fr_lsb ? {l_din, rx_sh[7:1]} : {rx_sh[6:0], l_din};
              next_half = 1'b1;
              if (bitn == 3'h7) begin
                next_lst = LNK_DONE;
              end
            end else begin
              next_sclk = ~l_cpol;
              next_mosi = fr_lsb ? tx_sh[0] : tx_sh[7];
              next_tx_sh = fr_lsb ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
              next_half = 1'b0;
              next_bitn = bitn + 3'h1;
            end
          end
        end
        LNK_DONE: begin
          if (tick) begin
            next_sel = 1'b1;
            if (fr_re) begin
              next_l_rxw = rx_sh;
              next_l_rx_tog = ~l_rx_tog;
            end
            next_l_end_tog = ~l_end_tog;
            next_l_busy = 1'b0;
            next_lst = LNK_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge peripheral_clock_i) begin
    if (l_rst) begin
      lst <= LNK_IDLE;
      cnt <= 7'h00;
      bitn <= 3'h0;
      half <= 1'b0;
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      l_rxw <= 8'h00;
      fr_lsb <= 1'b0;
      fr_re <= 1'b0;
      fr_auto <= 1'b0;
      l_rx_tog <= 1'b0;
      l_end_tog <= 1'b0;
      l_ack_tog <= 1'b0;
      l_busy <= 1'b0;
      serial_clock_out_o <= 1'b0;
      serial_data_out_o <= 1'b0;
      slave_select_out_o <= 1'b1;
    end else begin
      lst <= next_lst;
      cnt <= next_cnt;
      bitn <= next_bitn;
      half <= next_half;
      tx_sh <= next_tx_sh;
      rx_sh <= next_rx_sh;
      l_rxw <= next_l_rxw;
      fr_lsb <= next_fr_lsb;
      fr_re <= next_fr_re;
      fr_auto <= next_fr_auto;
      l_rx_tog <= next_l_rx_tog;
      l_end_tog <= next_l_end_tog;
      l_ack_tog <= next_l_ack_tog;
      l_busy <= next_l_busy;
      serial_clock_out_o <= next_sclk;
      serial_data_out_o <= next_mosi;
      slave_select_out_o <= next_sel;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_idle_clock_level: assert property (@(posedge peripheral_clock_i) disable iff (l_rst)
    (lst == LNK_IDLE && !l_go) |=> serial_clock_out_o == $past(l_cpol))
    else $error("serial clock not at idle level");
  a_idle_select_high: assert property (@(posedge peripheral_clock_i) disable iff (l_rst)
    (lst == LNK_IDLE) |-> slave_select_out_o)
    else $error("select low while idle");
  a_auto_select_low: assert property (@(posedge peripheral_clock_i) disable iff (l_rst)
    (lst == LNK_SHIFT && fr_auto) |-> !slave_select_out_o)
    else $error("select high during automatic frame");
  a_eighth_bit_end: assert property (@(posedge peripheral_clock_i) disable iff (l_rst)
    (lst == LNK_SHIFT && tick && !half && bitn == 3'h7 && l_en && l_te) |=> lst == LNK_DONE)
    else $error("frame did not end after eighth sample");
  a_busy_in_frame: assert property (@(posedge peripheral_clock_i) disable iff (l_rst)
    (lst == LNK_SHIFT) |-> l_busy)
    else $error("busy low during shifting");
  a_rx_full_set: assert property (@(posedge mclk_i) disable iff (rst_i)
    rx_evt |=> rx_full && rx_hold == $past(l_rxw))
    else $error("receive holding not filled");
  a_overrun_set: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rx_evt && rx_full && !(sfr_rd_i && sfr_addr_i == OFS_RX_HOLD)) |=> ovr_flag)
    else $error("overrun not flagged");
  a_status_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
    (sfr_rd_i && sfr_addr_i == OFS_STATUS && !end_evt) |=> !end_flag)
    else $error("transfer-end flag survived status read");
  a_irq_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
    (|(status[3:0] & irq_enable[3:0])) |=> spi_irq_o)
    else $error("interrupt not raised");
  a_tx_empty_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
    (sfr_wr_i && sfr_addr_i == OFS_TX_HOLD && !tx_full) |=> !status[STA_TX_EMPTY])
    else $error("transmit-empty not cleared by write");
  c_byte_received: cover property (@(posedge mclk_i) disable iff (rst_i) rx_evt);
  c_overrun: cover property (@(posedge mclk_i) disable iff (rst_i) rx_evt && rx_full);
  c_lsb_frame: cover property (@(posedge peripheral_clock_i) disable iff (l_rst)
    lst == LNK_DONE && fr_lsb);
  c_back_to_back: cover property (@(posedge peripheral_clock_i) disable iff (l_rst)
    lst == LNK_DONE ##1 lst == LNK_IDLE ##1 lst == LNK_LEAD);
endmodule : smd_top
`default_nettype wire

// File: test/smd_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module smd_slave_model (
  // Serial pins seen from the slave
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic ss_n_i,
  output logic miso_o,
  // Mode and data set by the bench
  input wire logic cpol_i,
  input wire logic lsb_i,
  input wire logic sel_gnd_i,
  input wire logic [7:0] tx_i,
  output logic [7:0] rx_o
);
  logic [7:0] sh = 8'h00;
  logic lead = 1'b0;
  int cnt = 0;
  initial begin
    miso_o = 1'b0;
    rx_o = 8'h00;
  end
  // Only a trailing edge after a leading one counts, so idle level moves are ignored
  always @(sclk_i) begin
    // Deselected slave ignores the clock, so idle level moves between frames do not count
    if (!sel_gnd_i && ss_n_i !== 1'b0) begin
      lead = 1'b0;
    end else if (sclk_i !== cpol_i) begin
      lead = 1'b1;
      miso_o <= tx_i[lsb_i ? cnt : 7 - cnt];
    end else if (lead) begin
      lead = 1'b0;
      sh[lsb_i ? cnt : 7 - cnt] = mosi_i;
      cnt = cnt + 1;
      if (cnt == 8) begin
        rx_o = sh;
        cnt = 0;
      end
    end
  end
  // Released line shows the inverse of its last value
  always @(posedge ss_n_i) begin
    cnt = 0;
    lead = 1'b0;
    if (!sel_gnd_i) miso_o <= ~miso_o;
  end
endmodule : smd_slave_model
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
  import smd_pkg::*;
;
  logic mclk = 1'b0, lclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, s_tx = 8'h00, st, d;
  logic s_cpol = 1'b0, s_lsb = 1'b0, s_gnd = 1'b0;
  wire logic [7:0] rdata, s_rx;
  wire logic irq, sclk, mosi, ss_n, miso;
  int num_errors = 0;
  int num_checks = 0;
  always #2.5 mclk = ~mclk;
  always #24 lclk = ~lclk;
  smd_top dut (.mclk_i(mclk), .peripheral_clock_i(lclk), .rst_i(rst), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .spi_irq_o(irq),
    .serial_clock_out_o(sclk), .serial_data_out_o(mosi), .slave_select_out_o(ss_n),
    .serial_data_in_i(miso));
  smd_slave_model slave (.sclk_i(sclk), .mosi_i(mosi), .ss_n_i(ss_n), .miso_o(miso),
    .cpol_i(s_cpol), .lsb_i(s_lsb), .sel_gnd_i(s_gnd), .tx_i(s_tx), .rx_o(s_rx));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : check8
  task automatic check_ns(input realtime got, input realtime exp);
    num_checks++;
    if (got != exp) begin
      num_errors++;
      $display("[FAIL] %0t period %0.2f expected %0.2f", $time, got, exp);
    end
  endtask : check_ns
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk) #1;
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(posedge mclk) #1;
    wr = 1'b0;
  endtask : sfr_wr
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk) #1;
    addr = a;
    rd = 1'b1;
    @(posedge mclk) #1;
    rd = 1'b0;
    @(posedge mclk) #1;
    v = rdata;
  endtask : sfr_rd
  task automatic wait_status(input int pos);
    int i;
    for (i = 0; i < 2000; i++) begin
      sfr_rd(OFS_STATUS, st);
      if (st[pos] === 1'b1) break;
    end
    check8({7'h00, st[pos]}, 8'h01);
  endtask : wait_status
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_regs;
    check8({6'h00, sclk, ss_n}, 8'h01);
    sfr_rd(OFS_PRESCALER, d); check8(d, 8'h04);
    sfr_rd(OFS_STATUS, d); check8(d, 8'h02);
    sfr_rd(OFS_CONTROL, d); check8(d, 8'h00);
    sfr_rd(OFS_IRQ_ENABLE, d); check8(d, 8'h00);
    sfr_wr(OFS_PRESCALER, 8'hff); sfr_rd(OFS_PRESCALER, d); check8(d, 8'hfc);
    sfr_wr(OFS_IRQ_ENABLE, 8'hff); sfr_rd(OFS_IRQ_ENABLE, d); check8(d, 8'h0f);
    sfr_wr(OFS_CONTROL, 8'hff); sfr_rd(OFS_CONTROL, d); check8(d, 8'h7e);
    sfr_wr(OFS_CONTROL, 8'h00);
    sfr_wr(OFS_IRQ_ENABLE, 8'h00);
    sfr_wr(OFS_STATUS, 8'hff); sfr_rd(OFS_STATUS, d); check8(d, 8'h02);
    sfr_rd(8'h10, d); check8(d, 8'h00);
    // Weights 8 and 4 sum to a divisor of 12
    sfr_wr(OFS_PRESCALER, 8'h0c);
  endtask : t_reset_regs
  task automatic t_byte(input logic [7:0] ctl, input logic [7:0] tx, input logic [7:0] stx);
    realtime t0;
    int i;
    s_cpol = ctl[1];
    s_lsb = ctl[2];
    s_gnd = !ctl[3];
    s_tx = stx;
    sfr_wr(OFS_CONTROL, ctl);
    for (i = 0; i < 100 && sclk !== ctl[1]; i++) @(posedge mclk);
    check8({7'h00, sclk}, {7'h00, ctl[1]});
    sfr_wr(OFS_TX_HOLD, tx);
    sfr_rd(OFS_STATUS, st); check8({7'h00, st[1]}, 8'h00);
    wait (sclk !== ctl[1]);
    t0 = $realtime;
    check8({7'h00, ss_n}, {7'h00, !ctl[3]});
    wait (sclk === ctl[1]);
    wait (sclk !== ctl[1]);
    check_ns($realtime - t0, 576.0);
    sfr_rd(OFS_STATUS, st); check8({7'h00, st[4]}, 8'h01);
    wait_status(STA_XFER_END);
    check8({7'h00, ss_n}, 8'h01);
    check8({7'h00, st[0]}, {7'h00, ctl[5]});
    check8(s_rx, tx);
    if (ctl[5]) begin
      sfr_rd(OFS_RX_HOLD, d); check8(d, stx);
    end
    sfr_rd(OFS_STATUS, st); check8(st, 8'h02);
  endtask : t_byte
  task automatic t_overrun_irq;
    int i;
    s_cpol = 1'b0;
    s_lsb = 1'b0;
    s_gnd = 1'b0;
    s_tx = 8'he7;
    sfr_wr(OFS_CONTROL, 8'h78);
    sfr_wr(OFS_TX_HOLD, 8'h11);
    wait_status(STA_TX_EMPTY);
    sfr_wr(OFS_TX_HOLD, 8'h22);
    wait_status(STA_XFER_END);
    sfr_wr(OFS_IRQ_ENABLE, 8'h0c);
    for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge mclk);
    check8({7'h00, irq}, 8'h01);
    sfr_rd(OFS_STATUS, st); check8(st & 8'h0f, 8'h0f);
    repeat (3) @(posedge mclk);
    check8({7'h00, irq}, 8'h00);
    check8(s_rx, 8'h22);
    sfr_wr(OFS_IRQ_ENABLE, 8'h01);
    repeat (3) @(posedge mclk);
    check8({7'h00, irq}, 8'h01);
    sfr_rd(OFS_RX_HOLD, d); check8(d, 8'he7);
    repeat (3) @(posedge mclk);
    check8({7'h00, irq}, 8'h00);
    sfr_wr(OFS_IRQ_ENABLE, 8'h02);
    repeat (3) @(posedge mclk);
    check8({7'h00, irq}, 8'h01);
    sfr_wr(OFS_IRQ_ENABLE, 8'h00);
  endtask : t_overrun_irq
  task automatic t_halt(input logic [7:0] ctl, input logic idle);
    int i;
    int moved;
    moved = 0;
    sfr_wr(OFS_CONTROL, ctl);
    for (i = 0; i < 100 && sclk !== idle; i++) @(posedge mclk);
    for (i = 0; i < 600; i++) begin
      @(posedge mclk);
      if (sclk !== idle || ss_n !== 1'b1) moved++;
    end
    check8((moved != 0) ? 8'hff : 8'h00, 8'h00);
  endtask : t_halt
  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    // Link side needs several of its own clocks to leave reset
    repeat (6) @(posedge lclk);
    @(posedge mclk) #1;
    rst = 1'b0;
    t_reset_regs();
    for (int m = 0; m < 4; m++) begin
      t_byte(8'h78 | {5'h00, m[1], m[0], 1'b0}, 8'ha5 ^ m[7:0], 8'h3c + m[7:0]);
    end
    t_byte(8'h70, 8'h96, 8'h5a);
    t_byte(8'h58, 8'h69, 8'hc3);
    t_overrun_irq();
    t_halt(8'h32, 1'b1);
    sfr_wr(OFS_TX_HOLD, 8'h33);
    t_halt(8'h60, 1'b0);
    s_cpol = 1'b0;
    sfr_wr(OFS_CONTROL, 8'h78);
    wait_status(STA_XFER_END);
    check8(s_rx, 8'h33);
    test_done();
  end
  initial begin
    #400000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end
endmodule : testbench
`default_nettype wire
